// ### core/ldsl_host.sv
// Host end: byte-oriented serial master that sends two or three bytes then strobes.
// Assumes i_mclk drives the link clock through a divider; user holds request data until accepted.
`timescale 1ns/1ns
`default_nettype none
module ldsl_host
	import ldsl_pkg::*;
(
	// Clock, reset, enable
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_ce,
	// Request
	input wire logic i_req,
	input wire logic i_alarm,
	input wire logic [ALARM_BITS-1:0] i_code,
	input wire logic i_invert,
	output logic o_ready,
	output logic o_done,
	// Link
	ldsl_if.host link
);
	ldsl_state_e state_reg, state_next;
	logic [23:0] data_reg, data_next;
	logic [1:0] bytes_reg, bytes_next;
	logic [2:0] bit_reg, bit_next;
	logic [2:0] div_reg, div_next;
	logic sclk_reg, sclk_next, load_reg, load_next, done_reg, done_next, inv_reg, inv_next;

	always_comb begin
		state_next = state_reg;
		data_next = data_reg;
		bytes_next = bytes_reg;
		bit_next = bit_reg;
		div_next = div_reg;
		sclk_next = sclk_reg;
		load_next = load_reg;
		done_next = 1'b0;
		inv_next = inv_reg;
		if (div_reg != 3'h0) begin
			div_next = div_reg - 3'h1;
		end else begin
			div_next = 3'(SCLK_HALF_DIV - 1);
			case (state_reg)
				LDSL_IDLE: begin
					div_next = 3'h0;
					if (i_req) begin
						inv_next = i_invert; // [R10]
						// Alarm: 24 bits, top 7 padding, kept last 17 [R7] [R6]
						data_next = i_alarm ? {7'h00, i_code} : {i_code[NORM_BITS-1:0], 8'h00};
						bytes_next = i_alarm ? 2'h2 : 2'h1; // [R8]
						state_next = LDSL_ASSERT;
					end
				end
				LDSL_ASSERT: begin
					load_next = 1'b0; // [R8]
					bit_next = 3'h7;
					state_next = LDSL_LOW;
				end
				LDSL_LOW: begin
					sclk_next = 1'b1; // [R9]
					state_next = LDSL_HIGH;
				end
				LDSL_HIGH: begin
					sclk_next = 1'b0;
					data_next = {data_reg[22:0], 1'b0}; // [R14]
					bit_next = bit_reg - 3'h1;
					if (bit_reg != 3'h0) begin
						state_next = LDSL_LOW;
					end else begin
						state_next = LDSL_NEXT;
					end
				end
				LDSL_NEXT: begin
					bit_next = 3'h7;
					if (bytes_reg != 2'h0) begin
						bytes_next = bytes_reg - 2'h1;
						state_next = LDSL_LOW;
					end else begin
						state_next = LDSL_STROBE;
					end
				end
				LDSL_STROBE: begin
					load_next = 1'b1; // [R8]
					done_next = 1'b1;
					state_next = LDSL_IDLE;
				end
				default: state_next = LDSL_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			state_reg <= LDSL_IDLE;
			data_reg <= 24'h000000;
			bytes_reg <= 2'h0;
			bit_reg <= 3'h0;
			div_reg <= 3'h0;
			sclk_reg <= 1'b0;
			load_reg <= 1'b1;
			done_reg <= 1'b0;
			inv_reg <= 1'b0;
		end else if (i_ce) begin
			state_reg <= state_next;
			data_reg <= data_next;
			bytes_reg <= bytes_next;
			bit_reg <= bit_next;
			div_reg <= div_next;
			sclk_reg <= sclk_next;
			load_reg <= load_next;
			done_reg <= done_next;
			inv_reg <= inv_next;
		end
	end

	// Data changes on the falling side, stable at the rise [R9]
	assign link.sdata = data_reg[23] ^ inv_reg;
	assign link.sclk = sclk_reg ^ inv_reg;
	assign link.load = load_reg ^ inv_reg;
	// Requests are only taken once the post-strobe gap has run out
	assign o_ready = (state_reg == LDSL_IDLE) && (div_reg == 3'h0);
	assign o_done = done_reg;
endmodule
`default_nettype wire

// ### core/ldsl_pkg.sv
// Package for the loop DAC serial load link: widths, mode codes, frame constants.
// Assumes both ends import it whole.
package ldsl_pkg;
	localparam int NORM_BITS = 16;
	localparam int ALARM_BITS = 17;
	localparam int CNT_BITS = 5;
	localparam logic [4:0] ALARM_MIN_CNT = 5'h11;
	localparam int BYTE_BITS = 8;
	localparam logic [16:0] LATCH_RESET = 17'h00000;
	// Alarm codes of interest (3.5 mA, 16 mA, 24 mA)
	localparam logic [16:0] ALARM_CODE_3P5MA = 17'h03800;
	localparam logic [16:0] ALARM_CODE_16MA = 17'h10000;
	localparam logic [16:0] ALARM_CODE_24MA = 17'h18000;
	localparam int SCLK_HALF_DIV = 4;

	typedef enum logic [0:0] {
		LDSL_MODE_NORMAL = 1'b0,
		LDSL_MODE_ALARM = 1'b1
	} ldsl_mode_e;

	typedef enum logic [2:0] {
		LDSL_IDLE = 3'b000,
		LDSL_ASSERT = 3'b001,
		LDSL_LOW = 3'b010,
		LDSL_HIGH = 3'b011,
		LDSL_NEXT = 3'b100,
		LDSL_STROBE = 3'b101
	} ldsl_state_e;
endpackage

// ### core/ldsl_if.sv
// Three-wire serial load link: serial data, serial clock, load strobe.
// Assumes the host drives all three lines; the device only listens.
`timescale 1ns/1ns
`default_nettype none
interface ldsl_if;
	logic sdata;
	logic sclk;
	logic load;
	modport host (output sdata, output sclk, output load);
	modport device (input sdata, input sclk, input load);
endinterface
`default_nettype wire

// ### core/ldsl_device.sv
// Device end: shift register, edge counter, mode decision and DAC latch.
// Assumes the link lines are asynchronous to i_mclk and slower than 1/4 of it.
`timescale 1ns/1ns
`default_nettype none
// Function
// [R1] Programming over data, clock, strobe only
// [R2] Shift data in on serial clock rise
// [R3] Strobe rise copies shift register to latch
// [R4] Alarm mode: 17-bit code over 0-32 mA
// [R5] Alarm codes map to 3.5/16/24 mA
// [R6] Host keeps alarm codes in 3.5-24 mA; ldsl_host sends i_code as given and does not limit it
// [R7] Host may send alarm as three bytes
// [R8] Normal write: strobe low, two bytes, raise
// [R9] Host: eight clocks per byte, idle low
// [R10] Host accounts for isolator inversion
// [R11] Count edges modulo 32 to pick mode
// [R12] Alarm keeps last 17 bits shifted
// [R13] Normal mode latches 16 bits straight binary
// [R14] Words travel most significant bit first
// [R15] Latch holds between strobe rising edges
// [R16] Edge counter restarts after each strobe
module ldsl_device
	import ldsl_pkg::*;
(
	// Clock, reset, enable
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_ce,
	// Link
	ldsl_if.device link,
	// DAC latch output
	output logic [ALARM_BITS-1:0] o_dac_code,
	output logic o_alarm_mode,
	output logic o_latch_pulse
);
	logic [2:0] sclk_sync_reg, sclk_sync_next;
	logic [2:0] load_sync_reg, load_sync_next;
	logic [1:0] data_sync_reg, data_sync_next;
	logic [ALARM_BITS-1:0] shift_reg, shift_next;
	logic [CNT_BITS-1:0] cnt_reg, cnt_next;
	logic [ALARM_BITS-1:0] latch_reg, latch_next;
	logic mode_reg, mode_next;
	logic pulse_reg, pulse_next;
	logic sclk_rise, load_rise;

	// Only stage 1 and 2 feed edge detect; stage 0 is read by stage 1 alone
	assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
	assign load_rise = load_sync_reg[1] & ~load_sync_reg[2];

	always_comb begin
		sclk_sync_next = {sclk_sync_reg[1:0], link.sclk}; // [R1]
		load_sync_next = {load_sync_reg[1:0], link.load};
		data_sync_next = {data_sync_reg[0], link.sdata};
		shift_next = shift_reg;
		cnt_next = cnt_reg;
		latch_next = latch_reg;
		mode_next = mode_reg;
		pulse_next = 1'b0;
		// Data sync is one stage shorter than clock, so bit sampled is the one valid at the rise
		if (sclk_rise) begin
			shift_next = {shift_reg[ALARM_BITS-2:0], data_sync_reg[1]}; // [R2] [R14] [R12]
			cnt_next = cnt_reg + 5'h01; // [R11]
		end
		if (load_rise) begin
			pulse_next = 1'b1;
			cnt_next = '0; // [R16]
			if (cnt_reg >= ALARM_MIN_CNT) begin
				latch_next = shift_reg; // [R3] [R4] [R5]
				mode_next = LDSL_MODE_ALARM; // [R11]
			end else begin
				latch_next = {1'b0, shift_reg[NORM_BITS-1:0]}; // [R13]
				mode_next = LDSL_MODE_NORMAL;
			end
		end // otherwise latch untouched [R15]
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			sclk_sync_reg <= 3'h0;
			// Strobe idles high: a zero here would fake a strobe rise right after reset
			load_sync_reg <= 3'h7;
			data_sync_reg <= 2'h0;
			shift_reg <= LATCH_RESET;
			cnt_reg <= 5'h00;
			latch_reg <= LATCH_RESET;
			mode_reg <= LDSL_MODE_NORMAL;
			pulse_reg <= 1'b0;
		end else if (i_ce) begin
			sclk_sync_reg <= sclk_sync_next;
			load_sync_reg <= load_sync_next;
			data_sync_reg <= data_sync_next;
			shift_reg <= shift_next;
			cnt_reg <= cnt_next;
			latch_reg <= latch_next;
			mode_reg <= mode_next;
			pulse_reg <= pulse_next;
		end
	end

	assign o_dac_code = latch_reg;
	assign o_alarm_mode = mode_reg;
	assign o_latch_pulse = pulse_reg;
endmodule
`default_nettype wire

// ### tb/ldsl_link_asserts.sv
// Checker on the link lines and the device latch outputs.
// Assumes link lines are registered on i_mclk and not inverted.
`timescale 1ns/1ns
`default_nettype none
module ldsl_link_asserts
	import ldsl_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// Link and latch
	input wire logic sdata,
	input wire logic sclk,
	input wire logic load,
	input wire logic [ALARM_BITS-1:0] o_dac_code,
	input wire logic o_alarm_mode,
	input wire logic o_latch_pulse
);
	logic [5:0] cnt_reg, cnt_next;
	logic [1:0] prev_reg, prev_next;
	always_comb begin
		prev_next = {sclk, load};
		cnt_next = cnt_reg;
		if (prev_reg[0] && !load) begin
			cnt_next = 6'h00;
		end else if (!load && sclk && !prev_reg[1]) begin
			cnt_next = cnt_reg + 6'h01;
		end
	end
	always_ff @(posedge i_mclk) begin
		cnt_reg <= i_srst ? 6'h00 : cnt_next;
		prev_reg <= i_srst ? 2'h1 : prev_next;
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	sequence strobe_rise; $rose(load); endsequence
	sequence latch_seen; ##[2:4] o_latch_pulse; endsequence
	latch_after_a: assert property (strobe_rise |-> latch_seen) else $error("no latch");
	pulse_once_a: assert property (o_latch_pulse |=> !o_latch_pulse) else $error("long pulse");
	code_hold_a: assert property ($changed(o_dac_code) |-> o_latch_pulse) else $error("code moved");
	mode_count_a: assert property (o_latch_pulse |-> o_alarm_mode == (cnt_reg > 6'h10)) else $error("mode");
	normal_top_a: assert property (!o_alarm_mode |-> !o_dac_code[16]) else $error("bit16");
	frame_len_a: assert property (strobe_rise |-> cnt_reg == 6'h10 || cnt_reg == 6'h18) else $error("len");
	sclk_high_a: assert property ($rose(sclk) |-> sclk[*4]) else $error("short sclk");
	sclk_idle_a: assert property (load |-> !sclk) else $error("sclk idle");
	data_hold_a: assert property (sclk && $past(sclk) |-> $stable(sdata)) else $error("data moved");
endmodule
`default_nettype wire

// ### tb/loop_dac_serial_load_bench.sv
// Bench: host end drives device end; latch results checked from a queue.
// Assumes one frame in flight at a time.
`timescale 1ns/1ns
`default_nettype none
module loop_dac_serial_load_bench
	import ldsl_pkg::*;
;
	logic i_mclk = 1'b0;
	logic i_srst = 1'b1;
	logic i_req = 1'b0;
	logic i_alarm = 1'b0;
	logic [ALARM_BITS-1:0] i_code = 17'h00000;
	logic o_ready, o_done, o_alarm_mode, o_latch_pulse;
	logic [ALARM_BITS-1:0] o_dac_code;
	logic [ALARM_BITS:0] exp_q[$];
	int fail_count = 0;
	int total_checks = 0;
	ldsl_if link();
	always #4 i_mclk = ~i_mclk;
	ldsl_host ldsl_host_inst (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(1'b1), .i_req(i_req), .i_alarm(i_alarm),
		.i_code(i_code), .i_invert(1'b0), .o_ready(o_ready), .o_done(o_done), .link(link.host));
	ldsl_device ldsl_device_inst (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(1'b1), .link(link.device),
		.o_dac_code(o_dac_code), .o_alarm_mode(o_alarm_mode), .o_latch_pulse(o_latch_pulse));
	ldsl_link_asserts ldsl_link_asserts_inst (.i_mclk(i_mclk), .i_srst(i_srst), .sdata(link.sdata),
		.sclk(link.sclk), .load(link.load), .o_dac_code(o_dac_code), .o_alarm_mode(o_alarm_mode),
		.o_latch_pulse(o_latch_pulse));
	task automatic chk(input string name, input logic [ALARM_BITS:0] exp, input logic [ALARM_BITS:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic conclude();
		if (fail_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Normal frames carry only the low 16 bits, so bit 16 must drop
	task automatic send(input logic alarm, input logic [ALARM_BITS-1:0] code);
		exp_q.push_back(alarm ? {1'b1, code} : {2'b00, code[15:0]});
		i_req <= 1'b1;
		i_alarm <= alarm;
		i_code <= code;
		// Hold the request until ready is seen at an edge; the host takes it there
		repeat (64) begin
			@(posedge i_mclk);
			if (o_ready === 1'b1) break;
		end
		i_req <= 1'b0;
		repeat (1000) begin
			@(negedge i_mclk);
			if (o_done === 1'b1) break;
		end
		@(posedge i_mclk);
	endtask
	always @(negedge i_mclk) begin
		if (o_latch_pulse === 1'b1) begin
			chk("latch", exp_q.size() > 0 ? exp_q.pop_front() : 'x, {o_alarm_mode, o_dac_code});
		end
	end
	initial begin
		#400000;
		fail_count++;
		conclude();
	end
	initial begin
		logic [ALARM_BITS-1:0] tbl[5];
		tbl = '{ALARM_CODE_3P5MA, ALARM_CODE_16MA, ALARM_CODE_24MA, 17'h03c00, 17'h14000};
		void'($urandom(65703));
		repeat (12) @(posedge i_mclk);
		i_srst <= 1'b0;
		@(posedge i_mclk);
		send(1'b0, 17'h00000);
		send(1'b0, 17'h1ffff);
		foreach (tbl[k]) send(1'b1, tbl[k]);
		// Alternating lengths expose a counter that is not cleared per frame
		repeat (6) begin
			send(1'b0, 17'($urandom()));
			send(1'b1, ALARM_CODE_3P5MA + 17'($urandom_range(0, 32'h14800)));
		end
		repeat (8) @(posedge i_mclk);
		if (exp_q.size() != 0) fail_count++;
		conclude();
	end
endmodule
`default_nettype wire
